// >>> mtm_defines.vh
// constants for the main-tie-main transfer controller
`ifndef MTM_DEFINES_VH
`define MTM_DEFINES_VH
// clock and seconds tick
`define MTM_CLK_KHZ 200000
`define MTM_TICK_MS 1000
`define MTM_TICK_W 28
// register byte offsets
`define MTM_A_CTRL 8'h00
`define MTM_A_KEY 8'h04
`define MTM_A_TDL1 8'h08
`define MTM_A_TDL2 8'h0C
`define MTM_A_TRT1 8'h10
`define MTM_A_TRT2 8'h14
`define MTM_A_TNEU 8'h18
`define MTM_A_STAT 8'h1C
`define MTM_A_TMR 8'h20
// ctrl fields
`define MTM_CTRL_TEST 0
// unlock key, arbitrary value
`define MTM_KEY_VAL 16'hA5C3
// delay limits and reset values, whole seconds
`define MTM_TDL_MIN 10'h001
`define MTM_TDL_MAX 10'h03C
`define MTM_TRT_MIN 10'h00A
`define MTM_TRT_MAX 10'h258
`define MTM_TNEU_MIN 10'h000
`define MTM_TNEU_MAX 10'h00A
`define MTM_TDL_RST 10'h005
`define MTM_TRT_RST 10'h03C
`define MTM_TNEU_RST 10'h002
// breaker state codes
`define MTM_BS_OPEN 2'h0
`define MTM_BS_CLOSED 2'h1
`define MTM_BS_TRIP 2'h2
`define MTM_BS_OUT 2'h3
`endif

// >>> mtm_ctrl.v
// main-tie-main open-transition transfer controller with ahb-lite registers
// Operation
// - auto normal: both mains closed, tie open
// - sustained loss: open lost main, close tie
// - loss delay per supply, 1..60 s
// - re-transfer delay per supply, 10..600 s
// - neutral delay setting, 0..10 s
// - both healthy after transfer: go manual
// - remaining supply fails on tie: no commands
// - restore after tie loss, neutral, close tie
// - simultaneous double loss: take no action
// - restore after double loss, neutral, tie
// - both return together: no action
// - manual mode: operator opens/closes each breaker
// - never close a breaker while the other two are closed
// - trip: manual mode, lock breaker till reset
// - lockout input blocks automatic operation
// - expose remaining delay time while running
// - delay settings change only when unlocked
// - breaker state: open/closed/tripped/withdrawn
// - per-supply voltage available indication
// - pushbutton toggles automatic/manual mode
// - test mode: pushbuttons simulate supply loss
// - alarms for supply loss and trip
`timescale 1ns/1ps
`default_nettype none
`include "mtm_defines.vh"
module mtm_ctrl #(
  parameter TICK_CYCLES = `MTM_TICK_MS * `MTM_CLK_KHZ,
  parameter TICK_W = `MTM_TICK_W
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [1:0] src_fail,
  input wire [2:0] brk_closed,
  input wire [2:0] brk_trip,
  input wire [2:0] brk_out,
  input wire [2:0] trip_rst,
  input wire mode_pb,
  input wire [2:0] open_pb,
  input wire [2:0] close_pb,
  input wire lockout,
  output wire [2:0] close_cmd,
  output wire [2:0] open_cmd,
  output wire [5:0] brk_state,
  output wire [1:0] src_avail,
  output wire alarm_loss,
  output wire alarm_trip,
  output wire auto_mode,
  output wire [9:0] timer_remain,
  output wire timer_run
);
  localparam [3:0] S_MAN = 4'h0;
  localparam [3:0] S_NORM = 4'h1;
  localparam [3:0] S_WLOSS = 4'h2;
  localparam [3:0] S_OPEN = 4'h3;
  localparam [3:0] S_TIE = 4'h4;
  localparam [3:0] S_RET = 4'h5;
  localparam [3:0] S_DEAD = 4'h6;
  localparam [3:0] S_DBL = 4'h7;
  localparam [3:0] S_REST = 4'h8;
  localparam [3:0] S_NEU = 4'h9;
  localparam [3:0] S_CLTIE = 4'hA;
  localparam [TICK_W-1:0] TICK_LAST = TICK_CYCLES - 1;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edges
  wire [21:0] raw = {lockout, close_pb, open_pb, mode_pb, trip_rst, brk_out, brk_trip,
    brk_closed, src_fail};
  reg [21:0] s1_reg;
  reg [21:0] s2_reg;
  reg [21:0] s3_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= 22'h000000;
      s2_reg <= 22'h000000;
      s3_reg <= 22'h000000;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire [2:0] cl = s2_reg[4:2];
  wire [2:0] trp = s2_reg[7:5];
  wire [2:0] wd = s2_reg[10:8];
  wire [2:0] trst = s2_reg[13:11];
  wire lock = s2_reg[21];
  wire mode_edge = s2_reg[14] & ~s3_reg[14];
  wire [2:0] op_edge = s2_reg[17:15] & ~s3_reg[17:15];
  wire [2:0] cl_edge = s2_reg[20:18] & ~s3_reg[20:18];
  wire [2:0] trip_edge = trp & ~s3_reg[7:5];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg test_en_reg;
  reg unlock_reg;
  reg [9:0] set_reg [0:4];
  reg dp_wr_reg;
  reg [7:0] dp_addr_reg;
  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg [3:0] st_reg;
  reg [3:0] st_next;
  reg lost_reg;
  reg lost_next;
  reg auto_reg;
  reg [2:0] tlock_reg;
  reg [2:0] man_cl_reg;
  reg [2:0] man_op_reg;
  reg [9:0] tmr_reg;
  reg [TICK_W-1:0] tick_reg;
  reg [2:0] close_cmd_reg;
  reg [2:0] open_cmd_reg;
  reg [5:0] brk_state_reg;
  reg [1:0] src_avail_reg;
  reg alarm_loss_reg;
  reg alarm_trip_reg;
  reg timer_run_reg;
  reg go_man;
  reg tl;
  reg [9:0] tv;
  reg [2:0] wcl;
  reg [2:0] wop;
  reg [31:0] rd_mux;
  integer k;

  // simulated loss reuses the two main pushbuttons, so test mode mutes their open edges
  wire [1:0] src_ok = ~s2_reg[1:0] & ~(test_en_reg ? s2_reg[16:15] : 2'h0);
  wire auto_on = auto_reg & ~lock;
  wire rem = ~lost_reg;
  wire [2:0] lm = lost_reg ? 3'h2 : 3'h1;
  wire tmr_zero = (tmr_reg == 10'h000);
  // per breaker: the other two are both closed
  wire [2:0] blk = {cl[0] & cl[1], cl[0] & cl[2], cl[1] & cl[2]};

  ////////////////////////////////////////////////////////////////////////////
  // delay limits
  function [9:0] lim;
    input [2:0] i;
    input [9:0] v;
    reg [9:0] lo;
    reg [9:0] hi;
    begin
      if (i < 3'h2) begin
        lo = `MTM_TDL_MIN;
        hi = `MTM_TDL_MAX;
      end else if (i < 3'h4) begin
        lo = `MTM_TRT_MIN;
        hi = `MTM_TRT_MAX;
      end else begin
        lo = `MTM_TNEU_MIN;
        hi = `MTM_TNEU_MAX;
      end
      lim = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  wire ap = hsel & htrans[1] & hready;
  wire [2:0] widx = dp_addr_reg[4:2] - 3'h2;
  wire wset = (dp_addr_reg >= `MTM_A_TDL1) && (dp_addr_reg <= `MTM_A_TNEU);
  wire [2:0] ridx = haddr[4:2] - 3'h2;
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `MTM_A_CTRL: rd_mux = {31'h00000000, test_en_reg};
      `MTM_A_KEY: rd_mux = {31'h00000000, unlock_reg};
      `MTM_A_TDL1, `MTM_A_TDL2, `MTM_A_TRT1, `MTM_A_TRT2, `MTM_A_TNEU:
        rd_mux = {22'h000000, set_reg[ridx]};
      `MTM_A_STAT: rd_mux = {15'h0000, brk_state_reg, tlock_reg, src_avail_reg, lock,
        auto_reg, st_reg};
      `MTM_A_TMR: rd_mux = {15'h0000, timer_run_reg, 6'h00, tmr_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      test_en_reg <= 1'b0;
      unlock_reg <= 1'b0;
      for (k = 0; k < 5; k = k + 1) begin
        set_reg[k] <= (k < 2) ? `MTM_TDL_RST : ((k < 4) ? `MTM_TRT_RST : `MTM_TNEU_RST);
      end
    end else begin
      hreadyout_reg <= 1'b1;
      dp_wr_reg <= ap & hwrite;
      dp_addr_reg <= haddr[7:0];
      hrdata_reg <= (ap & ~hwrite) ? rd_mux : 32'h00000000;
      if (dp_wr_reg) begin
        if (dp_addr_reg == `MTM_A_CTRL) begin
          test_en_reg <= hwdata[`MTM_CTRL_TEST];
        end
        if (dp_addr_reg == `MTM_A_KEY) begin
          unlock_reg <= (hwdata[15:0] == `MTM_KEY_VAL);
        end
        if (wset && unlock_reg) begin
          set_reg[widx] <= lim(widx, hwdata[9:0]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always @* begin
    st_next = st_reg;
    lost_next = lost_reg;
    go_man = 1'b0;
    tl = 1'b0;
    tv = 10'h000;
    wcl = 3'h0;
    wop = 3'h0;
    if (!auto_on) begin
      st_next = S_MAN;
    end else begin
      case (st_reg)
        S_MAN: st_next = S_NORM;
        S_NORM: begin
          wcl = 3'h3;
          wop = 3'h4;
          if (src_ok == 2'h0) begin
            st_next = S_DBL;
          end else if (src_ok != 2'h3) begin
            lost_next = src_ok[0];
            st_next = S_WLOSS;
            tl = 1'b1;
            tv = set_reg[{2'h0, src_ok[0]}];
          end
        end
        S_WLOSS: begin
          wcl = 3'h3;
          wop = 3'h4;
          if (src_ok[lost_reg]) begin
            st_next = S_NORM;
          end else if (src_ok == 2'h0) begin
            st_next = S_DBL;
          end else if (tmr_zero) begin
            st_next = S_OPEN;
          end
        end
        S_OPEN: begin
          wop = lm;
          if ((cl & lm) == 3'h0) begin
            wcl = 3'h4;
          end
          if (!src_ok[rem]) begin
            st_next = S_DEAD;
          end else if (cl[2]) begin
            st_next = S_TIE;
          end
        end
        S_TIE, S_RET: begin
          wcl = ~lm;
          wop = lm;
          if (!src_ok[rem]) begin
            st_next = S_DEAD;
          end else if (st_reg == S_TIE) begin
            if (src_ok == 2'h3) begin
              st_next = S_RET;
              tl = 1'b1;
              tv = set_reg[{2'h1, lost_reg}];
            end
          end else if (!src_ok[lost_reg]) begin
            st_next = S_TIE;
          end else if (tmr_zero) begin
            go_man = 1'b1;
            st_next = S_MAN;
          end
        end
        S_DEAD: begin
          // no commands while everything is dead
          if (src_ok != 2'h0) begin
            lost_next = src_ok[0];
            st_next = S_REST;
          end
        end
        S_DBL: begin
          if (src_ok == 2'h3) begin
            st_next = S_NORM;
          end else if (src_ok != 2'h0) begin
            lost_next = src_ok[0];
            st_next = S_REST;
          end
        end
        S_REST, S_NEU: begin
          wop = lm | 3'h4;
          wcl = ~lm & 3'h3;
          if (!src_ok[rem]) begin
            st_next = S_DEAD;
          end else if (st_reg == S_REST) begin
            if (cl == (~lm & 3'h3)) begin
              st_next = S_NEU;
              tl = 1'b1;
              tv = set_reg[4];
            end
          end else if (tmr_zero) begin
            st_next = S_CLTIE;
          end
        end
        S_CLTIE: begin
          wcl = ~lm;
          wop = lm;
          if (!src_ok[rem]) begin
            st_next = S_DEAD;
          end else if (cl[2]) begin
            st_next = S_TIE;
          end
        end
        default: st_next = S_MAN;
      endcase
    end
    if (st_reg == S_MAN) begin
      wcl = man_cl_reg;
      wop = man_op_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= S_MAN;
      lost_reg <= 1'b0;
      auto_reg <= 1'b0;
      tlock_reg <= 3'h0;
      man_cl_reg <= 3'h0;
      man_op_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      lost_reg <= lost_next;
      if (go_man || (trip_edge != 3'h0)) begin
        auto_reg <= 1'b0;
      end else if (mode_edge) begin
        auto_reg <= ~auto_reg;
      end
      // a new trip wins over a reset seen in the same cycle
      tlock_reg <= (tlock_reg & ~trst) | trip_edge;
      if (auto_on) begin
        man_cl_reg <= 3'h0;
        man_op_reg <= 3'h0;
      end else begin
        // a close refused because the other two are closed is dropped, so it cannot fire later on its own
        man_cl_reg <= (man_cl_reg & ~cl & ~op_edge & ~blk) | (cl_edge & ~tlock_reg);
        man_op_reg <= (man_op_reg & cl & ~cl_edge) |
          (op_edge & ~tlock_reg & ~{1'b0, {2{test_en_reg}}});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay timer on the seconds tick
  wire tick = (tick_reg == TICK_LAST);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_reg <= 10'h000;
      tick_reg <= {TICK_W{1'b0}};
      timer_run_reg <= 1'b0;
    end else begin
      // restart the prescaler on load so the first second is a full one
      if (tl) begin
        tmr_reg <= tv;
        tick_reg <= {TICK_W{1'b0}};
      end else begin
        tick_reg <= tick ? {TICK_W{1'b0}} : tick_reg + 1'b1;
        if (tick && !tmr_zero) begin
          tmr_reg <= tmr_reg - 10'h001;
        end
      end
      timer_run_reg <= tl ? (tv != 10'h000) :
        (((st_reg == S_WLOSS) || (st_reg == S_RET) || (st_reg == S_NEU)) &&
        !tmr_zero && (st_next == st_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // breaker commands and indications
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_brk
      wire others_closed = &(cl | (3'h1 << g));
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          close_cmd_reg[g] <= 1'b0;
          open_cmd_reg[g] <= 1'b0;
          brk_state_reg[2*g+1:2*g] <= `MTM_BS_OPEN;
        end else begin
          close_cmd_reg[g] <= wcl[g] & ~wop[g] & ~cl[g] & ~trp[g] & ~wd[g] & ~tlock_reg[g] &
            ~others_closed;
          open_cmd_reg[g] <= wop[g] & cl[g];
          brk_state_reg[2*g+1:2*g] <= wd[g] ? `MTM_BS_OUT : (trp[g] ? `MTM_BS_TRIP :
            (cl[g] ? `MTM_BS_CLOSED : `MTM_BS_OPEN));
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_avail_reg <= 2'h0;
      alarm_loss_reg <= 1'b0;
      alarm_trip_reg <= 1'b0;
    end else begin
      src_avail_reg <= src_ok;
      alarm_loss_reg <= ~&src_ok;
      alarm_trip_reg <= |trp;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign close_cmd = close_cmd_reg;
  assign open_cmd = open_cmd_reg;
  assign brk_state = brk_state_reg;
  assign src_avail = src_avail_reg;
  assign alarm_loss = alarm_loss_reg;
  assign alarm_trip = alarm_trip_reg;
  assign auto_mode = auto_reg;
  assign timer_remain = tmr_reg;
  assign timer_run = timer_run_reg;
endmodule // mtm_ctrl
`default_nettype wire

// >>> mtm_placeholder_unused.v
// intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> mtm_ctrl_properties.sv
// port assertions for the transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "mtm_defines.vh"
module mtm_ctrl_props #(
  parameter TICK_CYCLES = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] src_fail,
  input wire logic [2:0] brk_closed,
  input wire logic [2:0] brk_trip,
  input wire logic [2:0] brk_out,
  input wire logic [2:0] open_pb,
  input wire logic [2:0] close_cmd,
  input wire logic [5:0] brk_state,
  input wire logic [1:0] src_avail,
  input wire logic alarm_loss,
  input wire logic alarm_trip,
  input wire logic auto_mode,
  input wire logic [9:0] timer_remain,
  input wire logic timer_run
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rdy; $past(hresetn) |-> hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rdz; !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("hrdata outside read");
  // sync takes up to three cycles, so stable runs of four
  property p_lock; (brk_closed[1:0] == 2'h3) [*4] |=> !close_cmd[2]; endproperty
  a_lock: assert property (p_lock) else $error("tie close with mains in");
  property p_wdr; brk_out[0] [*4] |=> brk_state[1:0] == `MTM_BS_OUT; endproperty
  a_wdr: assert property (p_wdr) else $error("withdrawn not shown");
  property p_avl;
    ({src_fail, open_pb[1:0]} == 4'h0) [*4] |=> src_avail == 2'h3 && !alarm_loss;
  endproperty
  a_avl: assert property (p_avl) else $error("supply not shown");
  property p_trp; brk_trip[0] [*4] |=> alarm_trip && !auto_mode; endproperty
  a_trp: assert property (p_trp) else $error("trip not handled");
  property p_cnt;
    timer_run && $past(timer_run) |-> timer_remain <= $past(timer_remain);
  endproperty
  a_cnt: assert property (p_cnt) else $error("timer counts up");
  c_tie: cover property ($rose(close_cmd[2]));
  c_tmr: cover property ($fell(timer_run));
  c_trp: cover property ($rose(alarm_trip));
endmodule  // mtm_ctrl_props
bind mtm_ctrl mtm_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) mtm_ctrl_props_inst (.*);
`default_nettype wire

// >>> mtm_brk_model.sv
// three breakers answering close and open commands
`timescale 1ns/1ps
`default_nettype none
module mtm_brk_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [2:0] close_cmd,
  input wire logic [2:0] open_cmd,
  input wire logic [2:0] trip,
  output logic [2:0] closed
);
  int cnt [3];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      closed <= 3'h0;
      cnt <= '{0, 0, 0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (trip[i]) begin
          closed[i] <= 1'b0;  // protection opens it at once
          cnt[i] <= 0;
        end else if ((close_cmd[i] ^ open_cmd[i]) && closed[i] != close_cmd[i]) begin
          cnt[i] <= cnt[i] + 1;
          if (cnt[i] >= (slow ? 8 : 1)) closed[i] <= close_cmd[i];
        end else begin
          cnt[i] <= 0;  // conflicting commands move nothing
        end
      end
    end
  end
endmodule  // mtm_brk_model
`default_nettype wire

// >>> main_tie_main_transfer_ctrl_bench.sv
// self-checking bench for the transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "mtm_defines.vh"
module main_tie_main_transfer_ctrl_bench;
  localparam int TK = 20;
  logic hclk, hresetn, hsel, hwrite, mode_pb, lockout, slow;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans, src_fail;
  logic [2:0] hsize, brk_trip, brk_out, trip_rst, open_pb, close_pb;
  wire hreadyout, hresp, alarm_loss, alarm_trip, auto_mode, timer_run;
  wire [31:0] hrdata;
  wire [2:0] brk_closed, close_cmd, open_cmd;
  wire [5:0] brk_state;
  wire [1:0] src_avail;
  wire [9:0] timer_remain;
  int miscompares, n_compared, n;
  logic [7:0] ta [10] = '{8'h08, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h08, 8'h0C, 8'h18,
    8'h14};
  logic [9:0] tw [10] = '{10'h000, 10'h03D, 10'h064, 10'h005, 10'h3E8, 10'h014, 10'h002,
    10'h002, 10'h001, 10'h00A};
  logic [9:0] te [10] = '{10'h001, 10'h03C, 10'h03C, 10'h00A, 10'h258, 10'h00A, 10'h002,
    10'h002, 10'h001, 10'h00A};

  mtm_ctrl #(.TICK_CYCLES(TK)) mtm_ctrl_inst (.hready(hreadyout), .*);
  mtm_brk_model mtm_brk_model_inst (.clk(hclk), .rst_n(hresetn), .slow, .close_cmd,
    .open_cmd, .trip(brk_trip), .closed(brk_closed));

  task automatic cyc(input int m);
    repeat (m) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for an edge with hready high
  task automatic hw;
    int k;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      miscompares++;
      conclude;
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hw;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    hw;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(hrdata, e);
  endtask
  task automatic wb(input logic [2:0] e, input int m);
    for (int i = 0; i < m && brk_closed !== e; i++) cyc(1);
    chk(32'(brk_closed), 32'(e));
  endtask
  // buttons act on edges, so press then release
  task automatic press(input logic [6:0] p);
    {mode_pb, open_pb, close_pb} <= p;
    cyc(4);
    {mode_pb, open_pb, close_pb} <= 7'h0;
    cyc(4);
  endtask

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    cyc(90000);
    miscompares++;
    conclude;
  end
  initial begin
    {hresetn, hsel, hwrite, mode_pb, lockout, slow} = 6'h0;
    {haddr, hwdata, htrans, src_fail} = 68'h0;
    {brk_trip, brk_out, trip_rst, open_pb, close_pb} = 15'h0;
    hsize = 3'h2;
    cyc(3);
    chk(32'(hreadyout), 32'h0);
    hresetn <= 1'b1;
    rc(`MTM_A_TDL1, 32'(`MTM_TDL_RST));
    rc(`MTM_A_TRT2, 32'(`MTM_TRT_RST));
    rc(`MTM_A_TNEU, 32'(`MTM_TNEU_RST));
    rc(8'h40, 32'h0);
    xf(1'b1, `MTM_A_TDL1, 32'h7);
    rc(`MTM_A_TDL1, 32'(`MTM_TDL_RST));
    xf(1'b1, `MTM_A_KEY, 32'(`MTM_KEY_VAL));
    rc(`MTM_A_KEY, 32'h1);
    for (int i = 0; i < 10; i++) begin
      xf(1'b1, ta[i], 32'(tw[i]));
      rc(ta[i], 32'(te[i]));
    end
    press(7'h40);
    chk(32'(auto_mode), 32'h1);
    wb(3'h3, 200);
    src_fail <= 2'h1;
    cyc(TK);
    chk(32'(timer_run), 32'h1);
    chk(32'(timer_remain), 32'h2);
    src_fail <= 2'h0;
    cyc(3 * TK);
    chk(32'(brk_closed), 32'h3);
    src_fail <= 2'h1;
    for (n = 0; open_cmd[0] !== 1'b1 && n < 200; n++) cyc(1);
    chk(32'(n >= 2 * TK && n <= 2 * TK + 10), 32'h1);
    wb(3'h6, 100);
    chk(32'({alarm_loss, src_avail}), 32'h6);
    src_fail <= 2'h0;
    for (n = 0; auto_mode !== 1'b0 && n < 400; n++) cyc(1);
    chk(32'(n >= 10 * TK && n <= 10 * TK + 12), 32'h1);
    cyc(TK);
    chk(32'(brk_closed), 32'h6);
    slow <= 1'b1;
    press(7'h01);
    cyc(30);
    chk(32'(brk_closed), 32'h6);
    press(7'h20);
    wb(3'h2, 50);
    cyc(30);
    chk(32'(brk_closed), 32'h2);
    press(7'h01);
    wb(3'h3, 50);
    brk_trip <= 3'h1;
    wb(3'h2, 20);
    cyc(4);
    chk(32'({alarm_trip, brk_state[1:0]}), 32'h6);
    brk_trip <= 3'h0;
    press(7'h01);
    cyc(20);
    chk(32'(brk_closed), 32'h2);
    trip_rst <= 3'h1;
    cyc(4);
    trip_rst <= 3'h0;
    press(7'h01);
    wb(3'h3, 50);
    brk_out <= 3'h4;
    cyc(4);
    chk(32'(brk_state[5:4]), 32'(`MTM_BS_OUT));
    brk_out <= 3'h0;
    slow <= 1'b0;
    lockout <= 1'b1;
    press(7'h40);
    src_fail <= 2'h2;
    cyc(100);
    chk(32'(brk_closed), 32'h3);
    src_fail <= 2'h0;
    lockout <= 1'b0;
    cyc(20);
    chk(32'(auto_mode), 32'h1);
    src_fail <= 2'h3;
    cyc(100);
    chk(32'({open_cmd, close_cmd, brk_closed}), 32'h3);
    src_fail <= 2'h0;
    cyc(100);
    chk(32'({open_cmd, close_cmd, brk_closed}), 32'h3);
    src_fail <= 2'h3;
    cyc(10);
    src_fail <= 2'h1;
    wb(3'h6, 100);
    src_fail <= 2'h3;
    cyc(50);
    chk(32'({open_cmd, close_cmd, brk_closed}), 32'h6);
    src_fail <= 2'h2;
    wb(3'h5, 200);
    xf(1'b1, `MTM_A_CTRL, 32'h1);
    {mode_pb, open_pb, close_pb} <= 7'h08;
    cyc(6);
    chk(32'({alarm_loss, src_avail}), 32'h4);
    {mode_pb, open_pb, close_pb} <= 7'h00;
    xf(1'b1, `MTM_A_CTRL, 32'h0);
    conclude;
  end
endmodule  // main_tie_main_transfer_ctrl_bench
`default_nettype wire
